// ---- shared/pad_function_mux_defines.svh ----
// offsets, fields and reset values of the pad selectors
`ifndef PAD_FUNCTION_MUX_DEFINES_SVH
`define PAD_FUNCTION_MUX_DEFINES_SVH

`define PAD12_FUNCTION_SELECT_OFFSET 8'h30
`define PAD13_FUNCTION_SELECT_OFFSET 8'h34
`define PAD14_FUNCTION_SELECT_OFFSET 8'h38
`define PAD15_FUNCTION_SELECT_OFFSET 8'h3c
`define PAD16_FUNCTION_SELECT_OFFSET 8'h40
`define PAD17_FUNCTION_SELECT_OFFSET 8'h44
`define PAD18_FUNCTION_SELECT_OFFSET 8'h48
`define PAD19_FUNCTION_SELECT_OFFSET 8'h4c
`define PAD20_FUNCTION_SELECT_OFFSET 8'h50
`define PAD21_FUNCTION_SELECT_OFFSET 8'h54
`define PAD22_FUNCTION_SELECT_OFFSET 8'h58
`define PAD23_FUNCTION_SELECT_OFFSET 8'h5c
`define PAD24_FUNCTION_SELECT_OFFSET 8'h60
`define PAD25_FUNCTION_SELECT_OFFSET 8'h64
`define PAD26_FUNCTION_SELECT_OFFSET 8'h68
`define PAD27_FUNCTION_SELECT_OFFSET 8'h6c
`define PFS_FIRST_OFFSET `PAD12_FUNCTION_SELECT_OFFSET
`define PFS_LAST_OFFSET `PAD27_FUNCTION_SELECT_OFFSET

// function code field of every selector
`define PFS_CODE_LSB 0
`define PFS_CODE_MSB 2
`define PFS_RESET_CODE 3'h0

// read value of unmapped addresses
`define PFS_UNMAPPED_READ 32'h0000_0000

`endif

// ---- shared/pad_function_mux_pkg.sv ----
// types of the pad mux
package pad_function_mux_pkg;

    typedef logic [2:0] func_code_t;

    // every signal a pad can carry
    typedef enum logic [5:0] {
        FN_NONE       = 6'h00,
        FN_GPIO       = 6'h01,
        FN_SS1_FRAME  = 6'h02,
        FN_SS1_TX     = 6'h03,
        FN_SS1_RX     = 6'h04,
        FN_SS1_CLK    = 6'h05,
        FN_A1_RTS_N   = 6'h06,
        FN_A1_TX      = 6'h07,
        FN_A1_RX      = 6'h08,
        FN_A0_CTS_N   = 6'h09,
        FN_A0_RX      = 6'h0a,
        FN_A0_TX      = 6'h0b,
        FN_T2_CH1     = 6'h0c,
        FN_T2_CH2     = 6'h0d,
        FN_T2_CH3     = 6'h0e,
        FN_T2_CH4     = 6'h0f,
        FN_T3_CH0     = 6'h10,
        FN_T3_CH1     = 6'h11,
        FN_T3_CH2     = 6'h12,
        FN_T3_CH3     = 6'h13,
        FN_T3_CH4     = 6'h14,
        FN_T1_CH5     = 6'h15,
        FN_TW1_SCL    = 6'h16,
        FN_TW1_SDA    = 6'h17,
        FN_TW0_SCL    = 6'h18,
        FN_TW0_SDA    = 6'h19,
        FN_CODEC_CLK  = 6'h1a,
        FN_BOOT5      = 6'h1b,
        FN_BOOT4      = 6'h1c,
        FN_WAKE0      = 6'h1d,
        FN_WAKE1      = 6'h1e,
        FN_COMP_POS   = 6'h1f,
        FN_COMP_NEG   = 6'h20,
        FN_SLOW_CLK   = 6'h21,
        FN_XTAL_IN    = 6'h22,
        FN_XTAL_OUT   = 6'h23,
        FN_VBUS       = 6'h24
    } route_t;

    localparam int FN_COUNT  = 37;
    localparam int PAD_COUNT = 16;
    localparam int TMR_COUNT = 10;

endpackage

// ---- src/pad_function_mux.sv ----
// pad 12 to 27 function mux with a classic wishbone slave
// Notes on behaviour
// RULE1: function code is selector bits two to zero
// RULE2: every selector resets to code zero
// RULE3: pad12 routes frame, rts, timer2 ch1, gpio
// RULE4: pad13 routes sync tx, async1 tx, timer2 ch2
// RULE5: pad14 routes sync rx, async1 rx, timer2 ch3
// RULE6: pad15 routes timer2 ch4 or gpio only
// RULE7: pad16 routes codec clock, strap bit5, gpio
// RULE8: pad17 routes twowire1 scl, timer3 ch0, gpio
// RULE9: pad18 routes sync clk, twowire1 sda, timer3 ch1
// RULE10: pad19 routes frame, twowire1 scl, timer3 ch2
// RULE11: pad20 routes sync tx, twowire0 sda, timer3 ch3
// RULE12: pad21 routes sync rx, twowire0 scl, timer3 ch4
// RULE13: pad22 code zero wake0, one gpio
// RULE14: pad23 routes comparator pos, cts, gpio, wake1
// RULE15: pad24 routes comparator neg, timer1, rx, slow clock
// RULE16: pad25 routes twowire1 sda, gpio, crystal input
// RULE17: pad26 routes twowire1 scl, gpio, crystal output
// RULE18: pad27 routes vbus drive, async0 tx, strap bit4
// RULE19: unused codes disconnect pad and idle inputs
// RULE20: unselected inputs idle; lowest pad index wins
//
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/1ns
`include "pad_function_mux_defines.svh"

module pad_function_mux (
    // clock and reset
    input  wire logic                             sys_clk_in,
    input  wire logic                             reset_in,
    // wishbone slave
    input  wire logic                             wb_cyc_in,
    input  wire logic                             wb_stb_in,
    input  wire logic                             wb_we_in,
    input  wire logic [7:0]                       wb_adr_in,
    input  wire logic [3:0]                       wb_sel_in,
    input  wire logic [31:0]                      wb_dat_in,
    output      logic [31:0]                      wb_dat_out,
    output      logic                             wb_ack_out,
    // pads 12 to 27, bit 0 is pad 12
    input  wire logic [pad_function_mux_pkg::PAD_COUNT-1:0] pad_level_in,
    output      logic [pad_function_mux_pkg::PAD_COUNT-1:0] pad_drive_out,
    output      logic [pad_function_mux_pkg::PAD_COUNT-1:0] pad_oe_out,
    // general purpose i/o
    input  wire logic [pad_function_mux_pkg::PAD_COUNT-1:0] gpio_drive_in,
    input  wire logic [pad_function_mux_pkg::PAD_COUNT-1:0] gpio_oe_in,
    output      logic [pad_function_mux_pkg::PAD_COUNT-1:0] gpio_level_out,
    // synchronous serial port 1
    input  wire logic                             sync_serial1_frame_drive_in,
    input  wire logic                             sync_serial1_frame_oe_in,
    output      logic                             sync_serial1_frame_out,
    input  wire logic                             sync_serial1_tx_in,
    output      logic                             sync_serial1_rx_out,
    input  wire logic                             sync_serial1_clk_drive_in,
    input  wire logic                             sync_serial1_clk_oe_in,
    output      logic                             sync_serial1_clk_out,
    // asynchronous serial ports
    input  wire logic                             async1_rts_n_in,
    input  wire logic                             async1_tx_in,
    output      logic                             async1_rx_out,
    output      logic                             async0_cts_n_out,
    output      logic                             async0_rx_out,
    input  wire logic                             async0_tx_in,
    // timer channels: t2 ch1..4, t3 ch0..4, t1 ch5
    input  wire logic [pad_function_mux_pkg::TMR_COUNT-1:0] timer_chan_drive_in,
    input  wire logic [pad_function_mux_pkg::TMR_COUNT-1:0] timer_chan_oe_in,
    output      logic [pad_function_mux_pkg::TMR_COUNT-1:0] timer_chan_out,
    // two-wire buses, open drain: high pulls the line low
    input  wire logic                             twowire1_scl_low_in,
    input  wire logic                             twowire1_sda_low_in,
    input  wire logic                             twowire0_scl_low_in,
    input  wire logic                             twowire0_sda_low_in,
    output      logic                             twowire1_scl_out,
    output      logic                             twowire1_sda_out,
    output      logic                             twowire0_scl_out,
    output      logic                             twowire0_sda_out,
    // clocks, straps, wake and analog inputs, bus power
    input  wire logic                             codec_ref_clock_in,
    input  wire logic                             boot_strap_bit5_drive_in,
    input  wire logic                             boot_strap_bit5_oe_in,
    output      logic                             boot_strap_bit5_out,
    input  wire logic                             boot_strap_bit4_drive_in,
    input  wire logic                             boot_strap_bit4_oe_in,
    output      logic                             boot_strap_bit4_out,
    output      logic                             wake_input0_out,
    output      logic                             wake_input1_out,
    output      logic                             ldo_comp_pos_out,
    output      logic                             ldo_comp_neg_out,
    input  wire logic                             slow_clock_in,
    output      logic                             slow_xtal_level_out,
    input  wire logic                             slow_xtal_drive_in,
    input  wire logic                             vbus_drive_in
);
    import pad_function_mux_pkg::*;

    // routing table: pad index 0 is pad 12
    function automatic route_t route_fn(input logic [3:0] pad, input func_code_t code);
        route_t r;
        r = FN_NONE; // unlisted codes stay disconnected [RULE19]
        unique case (pad)
            4'h0: begin
                if (code == 3'h3) r = FN_SS1_FRAME; // [RULE3]
                if (code == 3'h2) r = FN_A1_RTS_N; // [RULE3]
                if (code == 3'h1) r = FN_T2_CH1; // [RULE3]
                if (code == 3'h0) r = FN_GPIO; // [RULE3]
            end
            4'h1: begin
                if (code == 3'h3) r = FN_SS1_TX; // [RULE4]
                if (code == 3'h2) r = FN_A1_TX; // [RULE4]
                if (code == 3'h1) r = FN_T2_CH2; // [RULE4]
                if (code == 3'h0) r = FN_GPIO; // [RULE4]
            end
            4'h2: begin
                if (code == 3'h3) r = FN_SS1_RX; // [RULE5]
                if (code == 3'h2) r = FN_A1_RX; // [RULE5]
                if (code == 3'h1) r = FN_T2_CH3; // [RULE5]
                if (code == 3'h0) r = FN_GPIO; // [RULE5]
            end
            4'h3: begin
                if (code == 3'h1) r = FN_T2_CH4; // [RULE6]
                if (code == 3'h0) r = FN_GPIO; // [RULE6]
            end
            4'h4: begin
                if (code == 3'h3) r = FN_CODEC_CLK; // [RULE7]
                if (code == 3'h1) r = FN_BOOT5; // [RULE7]
                if (code == 3'h0) r = FN_GPIO; // [RULE7]
            end
            4'h5: begin
                if (code == 3'h2) r = FN_TW1_SCL; // [RULE8]
                if (code == 3'h1) r = FN_T3_CH0; // [RULE8]
                if (code == 3'h0) r = FN_GPIO; // [RULE8]
            end
            4'h6: begin
                if (code == 3'h3) r = FN_SS1_CLK; // [RULE9]
                if (code == 3'h2) r = FN_TW1_SDA; // [RULE9]
                if (code == 3'h1) r = FN_T3_CH1; // [RULE9]
                if (code == 3'h0) r = FN_GPIO; // [RULE9]
            end
            4'h7: begin
                if (code == 3'h3) r = FN_SS1_FRAME; // [RULE10]
                if (code == 3'h2) r = FN_TW1_SCL; // [RULE10]
                if (code == 3'h1) r = FN_T3_CH2; // [RULE10]
                if (code == 3'h0) r = FN_GPIO; // [RULE10]
            end
            4'h8: begin
                if (code == 3'h3) r = FN_SS1_TX; // [RULE11]
                if (code == 3'h2) r = FN_TW0_SDA; // [RULE11]
                if (code == 3'h1) r = FN_T3_CH3; // [RULE11]
                if (code == 3'h0) r = FN_GPIO; // [RULE11]
            end
            4'h9: begin
                if (code == 3'h3) r = FN_SS1_RX; // [RULE12]
                if (code == 3'h2) r = FN_TW0_SCL; // [RULE12]
                if (code == 3'h1) r = FN_T3_CH4; // [RULE12]
                if (code == 3'h0) r = FN_GPIO; // [RULE12]
            end
            4'ha: begin
                if (code == 3'h1) r = FN_GPIO; // [RULE13]
                if (code == 3'h0) r = FN_WAKE0; // [RULE13]
            end
            4'hb: begin
                if (code == 3'h5) r = FN_COMP_POS; // [RULE14]
                if (code == 3'h2) r = FN_A0_CTS_N; // [RULE14]
                if (code == 3'h1) r = FN_GPIO; // [RULE14]
                if (code == 3'h0) r = FN_WAKE1; // [RULE14]
            end
            4'hc: begin
                if (code == 3'h5) r = FN_COMP_NEG; // [RULE15]
                if (code == 3'h3) r = FN_T1_CH5; // [RULE15]
                if (code == 3'h2) r = FN_A0_RX; // [RULE15]
                if (code == 3'h1) r = FN_GPIO; // [RULE15]
                if (code == 3'h0) r = FN_SLOW_CLK; // [RULE15]
            end
            4'hd: begin
                if (code == 3'h2) r = FN_TW1_SDA; // [RULE16]
                if (code == 3'h1) r = FN_GPIO; // [RULE16]
                if (code == 3'h0) r = FN_XTAL_IN; // [RULE16]
            end
            4'he: begin
                if (code == 3'h2) r = FN_TW1_SCL; // [RULE17]
                if (code == 3'h1) r = FN_GPIO; // [RULE17]
                if (code == 3'h0) r = FN_XTAL_OUT; // [RULE17]
            end
            4'hf: begin
                if (code == 3'h3) r = FN_VBUS; // [RULE18]
                if (code == 3'h2) r = FN_A0_TX; // [RULE18]
                if (code == 3'h1) r = FN_BOOT4; // [RULE18]
                if (code == 3'h0) r = FN_GPIO; // [RULE18]
            end
        endcase
        return r;
    endfunction

    // level a peripheral input sees while no pad feeds it
    function automatic logic idle_level(input int f);
        return (f == int'(FN_A1_RX)) || (f == int'(FN_A0_RX)) || (f == int'(FN_A0_CTS_N)) ||
               (f == int'(FN_TW1_SCL)) || (f == int'(FN_TW1_SDA)) ||
               (f == int'(FN_TW0_SCL)) || (f == int'(FN_TW0_SDA));
    endfunction

    func_code_t              code_q [PAD_COUNT];
    route_t                  route_sel [PAD_COUNT];
    logic [FN_COUNT-1:0]     fn_drive;
    logic [FN_COUNT-1:0]     fn_oe;
    logic [FN_COUNT-1:0]     fn_level_d;
    logic [FN_COUNT-1:0]     fn_level_q;
    logic [PAD_COUNT-1:0]    gpio_level_d;
    logic [PAD_COUNT-1:0]    pad_drive_d;
    logic [PAD_COUNT-1:0]    pad_oe_d;
    logic                    bus_req;
    logic                    addr_hit;
    logic [7:0]              addr_off;
    logic [3:0]              sel_idx;
    logic                    ack_q;
    logic [31:0]             rdata_q;

    // bus decode: one aligned word per pad selector
    assign bus_req  = wb_cyc_in && wb_stb_in && !ack_q;
    assign addr_off = wb_adr_in - `PFS_FIRST_OFFSET;
    assign sel_idx  = addr_off[5:2];
    assign addr_hit = (wb_adr_in >= `PFS_FIRST_OFFSET) && (wb_adr_in <= `PFS_LAST_OFFSET) &&
                      (wb_adr_in[1:0] == 2'h0);

    // selector storage; only byte lane 0 carries the code
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            for (int p = 0; p < PAD_COUNT; p++) begin
                code_q[p] <= `PFS_RESET_CODE; // [RULE2]
            end
        end else if (bus_req && wb_we_in && addr_hit && wb_sel_in[0]) begin
            code_q[sel_idx] <= wb_dat_in[`PFS_CODE_MSB:`PFS_CODE_LSB]; // [RULE1]
        end
    end

    // one-cycle ack; unmapped reads give zero, writes there are dropped
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            ack_q   <= 1'b0;
            rdata_q <= `PFS_UNMAPPED_READ;
        end else begin
            ack_q <= bus_req;
            if (bus_req) begin
                rdata_q <= addr_hit ? {29'h0, code_q[sel_idx]} : `PFS_UNMAPPED_READ;
            end
        end
    end

    // what each peripheral would put on a pad
    always_comb begin
        fn_drive = '0;
        fn_oe    = '0;
        fn_drive[FN_SS1_FRAME] = sync_serial1_frame_drive_in;
        fn_oe[FN_SS1_FRAME]    = sync_serial1_frame_oe_in;
        fn_drive[FN_SS1_TX]    = sync_serial1_tx_in;
        fn_oe[FN_SS1_TX]       = 1'b1;
        fn_drive[FN_SS1_CLK]   = sync_serial1_clk_drive_in;
        fn_oe[FN_SS1_CLK]      = sync_serial1_clk_oe_in;
        fn_drive[FN_A1_RTS_N]  = async1_rts_n_in;
        fn_oe[FN_A1_RTS_N]     = 1'b1;
        fn_drive[FN_A1_TX]     = async1_tx_in;
        fn_oe[FN_A1_TX]        = 1'b1;
        fn_drive[FN_A0_TX]     = async0_tx_in;
        fn_oe[FN_A0_TX]        = 1'b1;
        for (int t = 0; t < TMR_COUNT; t++) begin
            fn_drive[int'(FN_T2_CH1) + t] = timer_chan_drive_in[t];
            fn_oe[int'(FN_T2_CH1) + t]    = timer_chan_oe_in[t];
        end
        // open drain: the pad only ever drives low
        fn_oe[FN_TW1_SCL]      = twowire1_scl_low_in;
        fn_oe[FN_TW1_SDA]      = twowire1_sda_low_in;
        fn_oe[FN_TW0_SCL]      = twowire0_scl_low_in;
        fn_oe[FN_TW0_SDA]      = twowire0_sda_low_in;
        fn_drive[FN_CODEC_CLK] = codec_ref_clock_in;
        fn_oe[FN_CODEC_CLK]    = 1'b1;
        fn_drive[FN_BOOT5]     = boot_strap_bit5_drive_in;
        fn_oe[FN_BOOT5]        = boot_strap_bit5_oe_in;
        fn_drive[FN_BOOT4]     = boot_strap_bit4_drive_in;
        fn_oe[FN_BOOT4]        = boot_strap_bit4_oe_in;
        fn_drive[FN_SLOW_CLK]  = slow_clock_in;
        fn_oe[FN_SLOW_CLK]     = 1'b1;
        fn_drive[FN_XTAL_OUT]  = slow_xtal_drive_in;
        fn_oe[FN_XTAL_OUT]     = 1'b1;
        fn_drive[FN_VBUS]      = vbus_drive_in;
        fn_oe[FN_VBUS]         = 1'b1;
    end

    // pad side and peripheral side of the routing
    always_comb begin
        for (int f = 0; f < FN_COUNT; f++) begin
            fn_level_d[f] = idle_level(f); // [RULE20]
        end
        gpio_level_d = '0;
        pad_drive_d  = '0;
        pad_oe_d     = '0;
        // walk down so the lowest pad selecting an input wins
        for (int p = PAD_COUNT - 1; p >= 0; p--) begin
            route_sel[p] = route_fn(4'(p), code_q[p]);
            if (route_sel[p] == FN_GPIO) begin
                pad_drive_d[p]  = gpio_drive_in[p];
                pad_oe_d[p]     = gpio_oe_in[p];
                gpio_level_d[p] = pad_level_in[p];
            end else if (route_sel[p] != FN_NONE) begin
                pad_drive_d[p] = fn_drive[route_sel[p]];
                pad_oe_d[p]    = fn_oe[route_sel[p]];
                fn_level_d[route_sel[p]] = pad_level_in[p]; // [RULE20]
            end
        end
    end

    // pads are registered so no combinational path reaches the board
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            pad_drive_out <= '0;
            pad_oe_out    <= '0;
        end else begin
            pad_drive_out <= pad_drive_d;
            pad_oe_out    <= pad_oe_d; // [RULE19]
        end
    end

    // peripheral inputs, registered; one cycle of latency on every routed input
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            for (int f = 0; f < FN_COUNT; f++) begin
                fn_level_q[f] <= idle_level(f);
            end
            gpio_level_out <= '0;
        end else begin
            fn_level_q     <= fn_level_d;
            gpio_level_out <= gpio_level_d;
        end
    end

    assign wb_ack_out             = ack_q;
    assign wb_dat_out             = rdata_q;
    assign sync_serial1_frame_out = fn_level_q[FN_SS1_FRAME];
    assign sync_serial1_rx_out    = fn_level_q[FN_SS1_RX];
    assign sync_serial1_clk_out   = fn_level_q[FN_SS1_CLK];
    assign async1_rx_out          = fn_level_q[FN_A1_RX];
    assign async0_cts_n_out       = fn_level_q[FN_A0_CTS_N];
    assign async0_rx_out          = fn_level_q[FN_A0_RX];
    assign timer_chan_out         = fn_level_q[FN_T1_CH5:FN_T2_CH1];
    assign twowire1_scl_out       = fn_level_q[FN_TW1_SCL];
    assign twowire1_sda_out       = fn_level_q[FN_TW1_SDA];
    assign twowire0_scl_out       = fn_level_q[FN_TW0_SCL];
    assign twowire0_sda_out       = fn_level_q[FN_TW0_SDA];
    assign boot_strap_bit5_out    = fn_level_q[FN_BOOT5];
    assign boot_strap_bit4_out    = fn_level_q[FN_BOOT4];
    assign wake_input0_out        = fn_level_q[FN_WAKE0];
    assign wake_input1_out        = fn_level_q[FN_WAKE1];
    assign ldo_comp_pos_out       = fn_level_q[FN_COMP_POS];
    assign ldo_comp_neg_out       = fn_level_q[FN_COMP_NEG];
    assign slow_xtal_level_out    = fn_level_q[FN_XTAL_IN];

endmodule

// ---- tb/pad_function_mux_props.sv ----
// port checks of the pad mux
`timescale 1ns/1ns
module pad_function_mux_props (
    input wire logic        sys_clk_in,
    input wire logic        reset_in,
    input wire logic        wb_cyc_in,
    input wire logic        wb_stb_in,
    input wire logic        wb_ack_out,
    input wire logic [31:0] wb_dat_out,
    input wire logic [15:0] pad_level_in,
    input wire logic [15:0] pad_oe_out,
    input wire logic [15:0] gpio_level_out,
    input wire logic        async1_rx_out,
    input wire logic        wake_input0_out,
    input wire logic        twowire1_scl_out,
    input wire logic        slow_xtal_level_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (reset_in);
    sequence s_req;
        wb_cyc_in && wb_stb_in && !wb_ack_out;
    endsequence
    sequence s_ack_pulse;
        wb_ack_out ##1 !wb_ack_out;
    endsequence
    property p_ack; s_req |=> s_ack_pulse; endproperty
    a_ack: assert property (p_ack) else $error("ack not one pulse");
    property p_ack_cause; $rose(wb_ack_out) |-> $past(wb_cyc_in && wb_stb_in); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_rd_code; wb_ack_out |-> wb_dat_out[31:3] == 29'h0; endproperty
    a_rd_code: assert property (p_rd_code) else $error("read bits above code");
    property p_reset;
        disable iff (1'b0) reset_in |=> pad_oe_out == 16'h0000 && !wb_ack_out;
    endproperty
    a_reset: assert property (p_reset) else $error("reset left outputs set");
    property p_gpio; (gpio_level_out & ~$past(pad_level_in)) == 16'h0000; endproperty
    a_gpio: assert property (p_gpio) else $error("gpio level not from pad");
    property p_a1_rx; !async1_rx_out |-> !$past(pad_level_in[2]); endproperty
    a_a1_rx: assert property (p_a1_rx) else $error("async1 rx low, pad14 high");
    property p_wake0; wake_input0_out |-> $past(pad_level_in[10]); endproperty
    a_wake0: assert property (p_wake0) else $error("wake0 high, pad22 low");
    property p_scl1; !twowire1_scl_out |-> ($past(pad_level_in) & 16'h40a0) != 16'h40a0; endproperty
    a_scl1: assert property (p_scl1) else $error("scl1 low, its pads high");
    property p_xtal; slow_xtal_level_out |-> $past(pad_level_in[13]); endproperty
    a_xtal: assert property (p_xtal) else $error("crystal in high, pad25 low");
endmodule

bind pad_function_mux pad_function_mux_props u_pad_function_mux_props (
    .sys_clk_in(sys_clk_in), .reset_in(reset_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
    .wb_ack_out(wb_ack_out), .wb_dat_out(wb_dat_out), .pad_level_in(pad_level_in), .pad_oe_out(pad_oe_out),
    .gpio_level_out(gpio_level_out), .async1_rx_out(async1_rx_out), .wake_input0_out(wake_input0_out),
    .twowire1_scl_out(twowire1_scl_out), .slow_xtal_level_out(slow_xtal_level_out));

// ---- tb/board_model.sv ----
// board side of the pads: pull-ups and drivers
`timescale 1ns/1ns
module board_model (
    input  wire logic [15:0] pad_drive_in,
    input  wire logic [15:0] pad_oe_in,
    input  wire logic [15:0] board_level_in,
    input  wire logic [15:0] board_oe_in,
    output      logic [15:0] pad_level_out
);
    // wired-and with pull-up: a released pad reads 1; contention is not flagged
    assign pad_level_out = (pad_drive_in | ~pad_oe_in) & (board_level_in | ~board_oe_in);
endmodule

// ---- tb/testbench.sv ----
// self-checking bench for the pad mux
`timescale 1ns/1ns
module testbench;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [45:0] req = '0;
    logic [15:0] gpio_drv = '0, gpio_oe = '0, brd_lvl = '0, brd_oe = '0, stim = '0;
    logic [9:0]  tmr_drv = '0, tmr_oe = '0;
    logic [3:0]  tw_low = '0;
    logic [31:0] rdat;
    logic [15:0] p_drv, p_oe, p_lvl, g_lvl;
    logic        ack, a1_rx, ss_rx, wake0, scl1;
    int          errors = 0, num_checks = 0;
    initial forever #10 clk = ~clk;
    pad_function_mux u_pad_function_mux (.sys_clk_in(clk), .reset_in(rst), .wb_cyc_in(req[45]),
        .wb_stb_in(req[45]), .wb_we_in(req[44]), .wb_sel_in(req[43:40]), .wb_adr_in(req[39:32]),
        .wb_dat_in(req[31:0]), .wb_dat_out(rdat), .wb_ack_out(ack), .pad_level_in(p_lvl),
        .pad_drive_out(p_drv), .pad_oe_out(p_oe), .gpio_drive_in(gpio_drv), .gpio_oe_in(gpio_oe),
        .gpio_level_out(g_lvl), .sync_serial1_frame_drive_in(stim[0]), .sync_serial1_frame_oe_in(stim[1]),
        .sync_serial1_frame_out(), .sync_serial1_tx_in(stim[2]), .sync_serial1_rx_out(ss_rx),
        .sync_serial1_clk_drive_in(stim[3]), .sync_serial1_clk_oe_in(stim[4]), .sync_serial1_clk_out(),
        .async1_rts_n_in(stim[5]), .async1_tx_in(stim[6]), .async1_rx_out(a1_rx), .async0_cts_n_out(),
        .async0_rx_out(), .async0_tx_in(stim[7]), .timer_chan_drive_in(tmr_drv), .timer_chan_oe_in(tmr_oe),
        .timer_chan_out(), .twowire1_scl_low_in(tw_low[0]), .twowire1_sda_low_in(tw_low[1]),
        .twowire0_scl_low_in(tw_low[2]), .twowire0_sda_low_in(tw_low[3]), .twowire1_scl_out(scl1),
        .twowire1_sda_out(), .twowire0_scl_out(), .twowire0_sda_out(), .codec_ref_clock_in(stim[8]),
        .boot_strap_bit5_drive_in(stim[9]), .boot_strap_bit5_oe_in(stim[10]), .boot_strap_bit5_out(),
        .boot_strap_bit4_drive_in(stim[11]), .boot_strap_bit4_oe_in(stim[12]), .boot_strap_bit4_out(),
        .wake_input0_out(wake0), .wake_input1_out(), .ldo_comp_pos_out(), .ldo_comp_neg_out(),
        .slow_clock_in(stim[13]), .slow_xtal_level_out(), .slow_xtal_drive_in(stim[14]), .vbus_drive_in(stim[15]));
    board_model u_board_model (.pad_drive_in(p_drv), .pad_oe_in(p_oe), .board_level_in(brd_lvl),
        .board_oe_in(brd_oe), .pad_level_out(p_lvl));
    task automatic print_verdict;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // held until the edge that samples ack
    task automatic wb(input logic [44:0] r, output logic [31:0] q);
        int n = 0;
        @(posedge clk);
        req <= {1'b1, r};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 16);
        q = rdat;
        req <= '0;
        if (ack !== 1'b1) begin
            errors++;
            print_verdict();
        end
    endtask
    task automatic wr(input int p, input logic [31:0] d, input logic [3:0] s = 4'h1);
        logic [31:0] q;
        wb({1'b1, s, 8'h30 + 8'(p * 4), d}, q);
    endtask
    task automatic rd(input int p, input logic [31:0] exp);
        logic [31:0] q;
        wb({1'b0, 4'hf, 8'h30 + 8'(p * 4), 32'h0}, q);
        chk(q, exp);
    endtask
    task automatic settle;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic t_regs;
        for (int p = 0; p < 16; p++) rd(p, 32'h0);
        for (int p = 0; p < 16; p++) begin
            wr(p, 32'hffff_fffd);
            wr(p, 32'h0000_0002, 4'h0);
            rd(p, 32'h5);
        end
        wr(16, 32'h7);
        rd(16, 32'h0);
    endtask
    task automatic t_route;
        for (int ph = 0; ph < 2; ph++) begin
            @(posedge clk);
            gpio_oe <= 16'hffff;
            gpio_drv <= {16{ph[0]}};
            tmr_oe <= 10'h3ff;
            tmr_drv <= {10{~ph[0]}};
            stim <= ph[0] ? 16'h10c0 : 16'h9804;
            for (int c = 0; c < 8; c++) begin
                wr(1, 32'(c));
                wr(15, 32'(c));
                settle();
                chk({p_oe[15], p_oe[1]}, c < 4 ? 2'b11 : 2'b00);
                chk({p_drv[15], p_drv[1]}, c < 4 ? {2{c[0] ^ ph[0]}} : 2'b00);
            end
        end
    endtask
    task automatic t_inputs;
        @(posedge clk);
        gpio_oe <= '0;
        brd_oe <= 16'h04a4;
        for (int v = 0; v < 2; v++) begin
            @(posedge clk);
            brd_lvl <= {16{v[0]}};
            wr(2, 32'h2);
            wr(10, 32'h0);
            settle();
            chk({a1_rx, wake0}, {2{v[0]}});
            wr(2, 32'h3);
            wr(10, 32'h1);
            settle();
            chk({a1_rx, ss_rx, wake0, g_lvl[10]}, {1'b1, v[0], 1'b0, v[0]});
            wr(2, 32'h7);
            settle();
            chk({a1_rx, ss_rx}, 2'b10);
        end
    endtask
    task automatic t_lowest;
        wr(5, 32'h2);
        wr(7, 32'h2);
        for (int v = 0; v < 2; v++) begin
            @(posedge clk);
            brd_lvl <= v ? 16'h0020 : 16'h0080;
            settle();
            chk(scl1, v[0]);
        end
        @(posedge clk);
        tw_low <= 4'h1;
        settle();
        chk({p_oe[5], p_drv[5], p_oe[7]}, 3'b101);
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_route();
        t_inputs();
        t_lowest();
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        rd(2, 32'h0);
        print_verdict();
    end
endmodule
